// [hw/oap_params.svh]
// Constants of the eight-port asynchronous adapter
`ifndef OAP_PARAMS_SVH
`define OAP_PARAMS_SVH
`define OAP_CLK_HZ 100000000
`define OAP_REF_HZ 12288000
`define OAP_REF_STEP (`OAP_REF_HZ / 1000)
`define OAP_REF_MOD (`OAP_CLK_HZ / 1000)
`define OAP_ARB_ADDR 16'h0130
`define OAP_SLOT_ADDR 16'h0102
`define OAP_CH_BASE 10'h008
`define OAP_R_DATA 3'h0
`define OAP_R_IER 3'h1
`define OAP_R_IIR 3'h2
`define OAP_R_LCR 3'h3
`define OAP_R_MCR 3'h4
`define OAP_R_LSR 3'h5
`define OAP_R_MSR 3'h6
`define OAP_FIFO_DEPTH 5'h10
`define OAP_MIN_BITS 4'h5
`define OAP_BIT_LAST 5'h0F
`define OAP_HALF_LAST 4'h7
`define OAP_STOP15_LAST 5'h17
`define OAP_STOP2_LAST 5'h1F
`define OAP_IID_NONE 4'h1
`define OAP_IID_LS 4'h6
`define OAP_IID_RX 4'h4
`define OAP_IID_TH 4'h2
`define OAP_IID_MS 4'h0
`define OAP_LCR_STB 2
`define OAP_LCR_PEN 3
`define OAP_LCR_EPS 4
`define OAP_LCR_BRK 6
`define OAP_LCR_DLAB 7
`define OAP_MCR_POL 3
`define OAP_SLOT_EN 7
`define OAP_MCR_RST 5'h00
`define OAP_SLOT_RST 8'h00
`endif

// [hw/oap_pkg.sv]
// Types of the eight-port asynchronous adapter
package oap_pkg;
  typedef enum logic [1:0] {
    OAP_RX_IDLE = 2'b00,
    OAP_RX_START = 2'b01,
    OAP_RX_DATA = 2'b10,
    OAP_RX_HOLD = 2'b11
  } oap_rx_e;
endpackage : oap_pkg

// [hw/oap_adapter.sv]
// Eight-port asynchronous adapter: channels, arbitration and request line
module oap_adapter (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host I/O access
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  output logic io_rdata_en_o,
  // Cascade between adapters
  input wire logic arb_pend_i,
  output logic arb_pend_o,
  // Open-collector request lines
  output logic [7:0] irq_out_o,
  output logic [7:0] irq_oe_n_o,
  // Serial ports
  input wire logic [7:0] rxd_i,
  input wire logic [7:0] cts_i,
  input wire logic [7:0] dsr_i,
  input wire logic [7:0] ri_i,
  input wire logic [7:0] dcd_i,
  output logic [7:0] txd_o,
  output logic [7:0] rts_o,
  output logic [7:0] dtr_o
);
`include "oap_params.svh"

  // Ones in the low k bits of a frame
  function automatic logic [9:0] msk(input logic [3:0] k);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) r[i] = (4'(i) < k);
    return r;
  endfunction : msk

  // Highest pending source of one channel
  function automatic logic [3:0] iid_f(input logic ls, rd, th, ms);
    if (ls) return `OAP_IID_LS;
    if (rd) return `OAP_IID_RX;
    if (th) return `OAP_IID_TH;
    if (ms) return `OAP_IID_MS;
    return `OAP_IID_NONE;
  endfunction : iid_f

  logic [16:0] acc, next_acc;
  logic [7:0][7:0] lcr, next_lcr, txm_n, rx_wd;
  logic [7:0][4:0] mcr, next_mcr, tw, next_tw, tr, next_tr;
  logic [7:0][4:0] rw, next_rw, rr, next_rr, tsc, next_tsc;
  logic [7:0][3:0] ier, next_ier, tnb, next_tnb, rnb, next_rnb;
  logic [7:0][3:0] rsc, next_rsc, iid_c;
  logic [7:0][15:0] dl, next_dl, bc, next_bc;
  logic [7:0][9:0] tsh, next_tsh, rsh, next_rsh;
  logic [7:0] fen, next_fen, tbz, next_tbz, thp, next_thp;
  logic [7:0] oe, next_oe, pe, next_pe, fe, next_fe, bi, next_bi;
  logic [7:0] txd, next_txd, rxs1, rxs2, rxs3, rxl, next_rxl;
  logic [7:0] tx_we, rx_we, clr_tx, clr_rx, slot, next_slot;
  logic [7:0] irq_oe_n, next_irq_oe_n;
  logic [31:0] ms_raw, ms1, ms2, ms3, msl, next_msl, msd, next_msd;
  logic [15:0] rdata, next_rdata;
  logic rden, next_rden, arbp, next_arbp, irq_req, pend_any;
  logic [2:0] port;
  logic [7:0] txm [8][16];
  logic [7:0] rxm [8][16];
  oap_pkg::oap_rx_e rxst [8];
  oap_pkg::oap_rx_e next_rxst [8];

  wire ch_hit = (io_addr_i[15:6] == `OAP_CH_BASE);
  wire [2:0] chn = io_addr_i[5:3];
  wire [2:0] ra = io_addr_i[2:0];
  wire dlab = lcr[chn][`OAP_LCR_DLAB];

  // Next state of every channel, the host access and the arbitration
  always_comb begin
    logic [9:0] fr, mk, mm;
    logic [3:0] n, m;
    logic [4:0] tcnt, rcnt, lim, slast;
    logic s16, rv, bit_o, perr, refk;
    logic [7:0] d;
    fr = '0; n = '0; m = '0; tcnt = '0; rcnt = '0; lim = '0; slast = '0;
    s16 = 1'b0; rv = 1'b0; bit_o = 1'b0; perr = 1'b0; d = '0;
    mk = '0; mm = '0; refk = 1'b0;
    next_lcr = lcr; next_mcr = mcr; next_ier = ier; next_dl = dl;
    next_bc = bc; next_tw = tw; next_tr = tr; next_rw = rw; next_rr = rr;
    next_tsc = tsc; next_tnb = tnb; next_rnb = rnb; next_rsc = rsc;
    next_tsh = tsh; next_rsh = rsh; next_fen = fen; next_tbz = tbz;
    next_thp = thp; next_oe = oe; next_pe = pe; next_fe = fe; next_bi = bi;
    next_txd = txd; next_rxst = rxst; next_slot = slot; next_msd = msd;
    next_rden = 1'b0; next_rdata = rdata;
    tx_we = '0; rx_we = '0; rx_wd = '0; clr_tx = '0; clr_rx = '0;
    for (int c = 0; c < 8; c++) txm_n[c] = txm[c][tr[c][3:0]];
    // Reference tick at 12.288 MHz from the 100 MHz clock
    refk = (acc + 17'(`OAP_REF_STEP)) >= 17'(`OAP_REF_MOD);
    next_acc = refk ? acc + 17'(`OAP_REF_STEP) - 17'(`OAP_REF_MOD)
                    : acc + 17'(`OAP_REF_STEP);
    // Modem inputs accepted when two stages agree; changes flagged
    next_rxl = (rxl & (rxs2 ^ rxs3)) | (rxs3 & ~(rxs2 ^ rxs3));
    next_msl = msl ^ (~(ms2 ^ ms3) & (ms3 ^ msl));
    // Interrupt identity per channel and fixed priority across ports
    pend_any = 1'b0;
    port = '0;
    for (int c = 7; c >= 0; c--) begin
      iid_c[c] = iid_f(ier[c][2] & (oe[c] | pe[c] | fe[c] | bi[c]),
                       ier[c][0] & (rw[c] != rr[c]), ier[c][1] & thp[c],
                       ier[c][3] & (|msd[4*c +: 4]));
      if (!iid_c[c][0]) begin
        pend_any = 1'b1;
        port = 3'(c);
      end
    end
    // Host writes
    if (io_wr_i && io_addr_i == `OAP_SLOT_ADDR) next_slot = io_wdata_i;
    if (io_wr_i && ch_hit) begin
      case (ra)
        `OAP_R_DATA: begin
          if (dlab) next_dl[chn][7:0] = io_wdata_i;
          else if (5'(tw[chn] - tr[chn]) != (fen[chn] ? `OAP_FIFO_DEPTH
                                                       : 5'h01)) begin
            tx_we[chn] = 1'b1;
            next_tw[chn] = tw[chn] + 5'h01;
            next_thp[chn] = 1'b0;
          end
        end
        `OAP_R_IER: begin
          if (dlab) next_dl[chn][15:8] = io_wdata_i;
          else next_ier[chn] = io_wdata_i[3:0];
        end
        `OAP_R_IIR: begin
          next_fen[chn] = io_wdata_i[0];
          clr_rx[chn] = io_wdata_i[1] | (io_wdata_i[0] != fen[chn]);
          clr_tx[chn] = io_wdata_i[2] | (io_wdata_i[0] != fen[chn]);
        end
        `OAP_R_LCR: next_lcr[chn] = io_wdata_i;
        `OAP_R_MCR: next_mcr[chn] = io_wdata_i[4:0];
        default: ;
      endcase
    end
    // Host reads and their side effects
    if (io_rd_i && io_addr_i == `OAP_ARB_ADDR) begin
      next_rden = pend_any && !arb_pend_i;
      next_rdata = {5'h00, slot[5:3], 1'b0, port, iid_c[port]};
    end else if (io_rd_i && io_addr_i == `OAP_SLOT_ADDR) begin
      next_rden = 1'b1;
      next_rdata = {8'h00, slot};
    end else if (io_rd_i && ch_hit) begin
      next_rden = 1'b1;
      next_rdata = '0;
      case (ra)
        `OAP_R_DATA: begin
          if (dlab) next_rdata[7:0] = dl[chn][7:0];
          else if (rw[chn] != rr[chn]) begin
            next_rdata[7:0] = rxm[chn][rr[chn][3:0]];
            next_rr[chn] = rr[chn] + 5'h01;
          end
        end
        `OAP_R_IER: next_rdata[7:0] = dlab ? dl[chn][15:8]
                                          : {4'h0, ier[chn]};
        `OAP_R_IIR: begin
          next_rdata[7:0] = {{2{fen[chn]}}, 2'b00, iid_c[chn]};
          if (iid_c[chn] == `OAP_IID_TH) next_thp[chn] = 1'b0;
        end
        `OAP_R_LCR: next_rdata[7:0] = lcr[chn];
        `OAP_R_MCR: next_rdata[7:0] = {3'h0, mcr[chn]};
        `OAP_R_LSR: begin
          next_rdata[7:0] = {1'b0, !tbz[chn] && tw[chn] == tr[chn],
                             tw[chn] == tr[chn], bi[chn], fe[chn], pe[chn],
                             oe[chn], rw[chn] != rr[chn]};
          {next_bi[chn], next_fe[chn], next_pe[chn], next_oe[chn]} = '0;
        end
        `OAP_R_MSR: begin
          next_rdata[7:0] = {msl[4*chn +: 4], msd[4*chn +: 4]};
          next_msd[4*chn +: 4] = '0;
        end
        default: ;
      endcase
    end
    next_msd = next_msd | (~(ms2 ^ ms3) & (ms3 ^ msl));
    // Per-channel baud divider, transmitter and receiver
    for (int c = 0; c < 8; c++) begin
      n = `OAP_MIN_BITS + {2'b00, lcr[c][1:0]};
      m = n + {3'h0, lcr[c][`OAP_LCR_PEN]} + 4'h1;
      // Masks of the data bits and of the whole frame after the start bit
      mk = msk(n);
      mm = msk(m);
      lim = fen[c] ? `OAP_FIFO_DEPTH : 5'h01;
      tcnt = 5'(tw[c] - tr[c]);
      rcnt = 5'(rw[c] - rr[c]);
      s16 = refk && dl[c] != '0 && bc[c] >= 16'(dl[c] - 16'h1);
      if (refk) next_bc[c] = s16 ? '0 : bc[c] + 16'h1;
      slast = !lcr[c][`OAP_LCR_STB] ? `OAP_BIT_LAST :
              (n == `OAP_MIN_BITS) ? `OAP_STOP15_LAST
                                   : `OAP_STOP2_LAST;
      // Transmitter: load a frame, shift bits, hold the stop time
      d = txm_n[c] & mk[7:0];
      if (!tbz[c] && tcnt != '0 && !clr_tx[c]) begin
        fr = '1;
        fr[0] = 1'b0;
        fr[8:1] = d | ~mk[7:0];
        if (lcr[c][`OAP_LCR_PEN])
          fr[n + 4'h1] = ^d ^ ~lcr[c][`OAP_LCR_EPS];
        next_tsh[c] = fr;
        next_tnb[c] = m;
        next_tsc[c] = '0;
        next_tbz[c] = 1'b1;
        next_tr[c] = tr[c] + 5'h01;
        if (tcnt == 5'h01) next_thp[c] = 1'b1;
      end else if (tbz[c] && s16) begin
        next_tsc[c] = tsc[c] + 5'h01;
        if (tnb[c] != '0 && tsc[c] == `OAP_BIT_LAST) begin
          next_tsh[c] = {1'b1, tsh[c][9:1]};
          next_tnb[c] = tnb[c] - 4'h1;
          next_tsc[c] = '0;
        end else if (tnb[c] == '0 && tsc[c] == slast) next_tbz[c] = 1'b0;
      end
      bit_o = (tbz[c] && tnb[c] != '0) ? tsh[c][0] : 1'b1;
      if (lcr[c][`OAP_LCR_BRK]) bit_o = 1'b0;
      next_txd[c] = bit_o ^ ~mcr[c][`OAP_MCR_POL];
      // Receiver: start check at mid-bit, sample, check and store
      rv = rxl[c] ^ ~mcr[c][`OAP_MCR_POL];
      fr = rsh[c];
      fr[rnb[c]] = rv;
      case (rxst[c])
        oap_pkg::OAP_RX_IDLE: if (s16 && !rv) begin
          next_rxst[c] = oap_pkg::OAP_RX_START;
          next_rsc[c] = '0;
        end
        oap_pkg::OAP_RX_START: if (s16) begin
          next_rsc[c] = rsc[c] + 4'h1;
          if (rsc[c] == `OAP_HALF_LAST) begin
            next_rxst[c] = rv ? oap_pkg::OAP_RX_IDLE : oap_pkg::OAP_RX_DATA;
            next_rsc[c] = '0;
            next_rnb[c] = '0;
          end
        end
        oap_pkg::OAP_RX_DATA: if (s16) begin
          next_rsc[c] = rsc[c] + 4'h1;
          if (rsc[c] == 4'(`OAP_BIT_LAST)) begin
            next_rsh[c] = fr;
            next_rnb[c] = rnb[c] + 4'h1;
            if (rnb[c] == m - 4'h1) begin
              d = fr[7:0] & mk[7:0];
              perr = lcr[c][`OAP_LCR_PEN] &&
                     ((^d ^ ~lcr[c][`OAP_LCR_EPS]) != fr[n]);
              next_pe[c] = next_pe[c] | perr;
              next_fe[c] = next_fe[c] | !fr[m - 4'h1];
              next_bi[c] = next_bi[c] | ((fr & mm) == '0);
              if (rcnt >= lim) next_oe[c] = 1'b1;
              else begin
                rx_we[c] = 1'b1;
                rx_wd[c] = d;
                next_rw[c] = rw[c] + 5'h01;
              end
              next_rxst[c] = fr[m - 4'h1] ? oap_pkg::OAP_RX_IDLE
                                          : oap_pkg::OAP_RX_HOLD;
            end
          end
        end
        oap_pkg::OAP_RX_HOLD: if (rv) next_rxst[c] = oap_pkg::OAP_RX_IDLE;
        default: next_rxst[c] = oap_pkg::OAP_RX_IDLE;
      endcase
      if (clr_tx[c]) next_tr[c] = tw[c];
      if (clr_rx[c]) next_rr[c] = next_rw[c];
    end
    // Request line drive and cascade to lower adapters
    next_irq_oe_n = '1;
    if (irq_req && slot[`OAP_SLOT_EN])
      next_irq_oe_n[slot[2:0]] = 1'b0;
    next_arbp = pend_any | arb_pend_i;
    for (int c = 0; c < 8; c++)
      ms_raw[4*c +: 4] = {dcd_i[c], ri_i[c], dsr_i[c], cts_i[c]};
  end

  // Registers of all channel and adapter state except the FIFO bytes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      acc <= '0; lcr <= '0; mcr <= {8{`OAP_MCR_RST}}; ier <= '0;
      dl <= '0; bc <= '0; tw <= '0; tr <= '0; rw <= '0; rr <= '0;
      tsc <= '0; tnb <= '0; rnb <= '0; rsc <= '0; tsh <= '0; rsh <= '0;
      fen <= '0; tbz <= '0; thp <= '0; oe <= '0; pe <= '0; fe <= '0;
      bi <= '0; txd <= '0; rxs1 <= '1; rxs2 <= '1; rxs3 <= '1; rxl <= '1;
      ms1 <= '0; ms2 <= '0; ms3 <= '0; msl <= '0; msd <= '0;
      rxst <= '{default: oap_pkg::OAP_RX_IDLE}; slot <= `OAP_SLOT_RST;
      rdata <= '0; rden <= 1'b0; arbp <= 1'b0; irq_req <= 1'b0;
      irq_oe_n <= '1;
    end else begin
      acc <= next_acc; lcr <= next_lcr; mcr <= next_mcr; ier <= next_ier;
      dl <= next_dl; bc <= next_bc; tw <= next_tw; tr <= next_tr;
      rw <= next_rw; rr <= next_rr; tsc <= next_tsc; tnb <= next_tnb;
      rnb <= next_rnb; rsc <= next_rsc; tsh <= next_tsh; rsh <= next_rsh;
      fen <= next_fen; tbz <= next_tbz; thp <= next_thp; oe <= next_oe;
      pe <= next_pe; fe <= next_fe; bi <= next_bi; txd <= next_txd;
      rxs1 <= rxd_i; rxs2 <= rxs1; rxs3 <= rxs2; rxl <= next_rxl;
      ms1 <= ms_raw; ms2 <= ms1; ms3 <= ms2; msl <= next_msl;
      msd <= next_msd; rxst <= next_rxst; slot <= next_slot;
      rdata <= next_rdata; rden <= next_rden; arbp <= next_arbp;
      irq_req <= pend_any; irq_oe_n <= next_irq_oe_n;
    end
  end

  // Byte storage of both FIFOs per channel
  always_ff @(posedge mclk_i) begin
    for (int c = 0; c < 8; c++) begin
      if (tx_we[c]) txm[c][tw[c][3:0]] <= io_wdata_i;
      if (rx_we[c]) rxm[c][rw[c][3:0]] <= rx_wd[c];
    end
  end

  // Outputs straight from flip-flops, except irq_out_o tied to zero
  assign io_rdata_o = rdata;
  assign io_rdata_en_o = rden;
  assign arb_pend_o = arbp;
  assign irq_out_o = '0;
  assign irq_oe_n_o = irq_oe_n;
  assign txd_o = txd;
  assign rts_o = {mcr[7][1], mcr[6][1], mcr[5][1], mcr[4][1],
                  mcr[3][1], mcr[2][1], mcr[1][1], mcr[0][1]};
  assign dtr_o = {mcr[7][0], mcr[6][0], mcr[5][0], mcr[4][0],
                  mcr[3][0], mcr[2][0], mcr[1][0], mcr[0][0]};

  // Checks on arbitration, request line, FIFO depth and line framing
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_arb_rd;
    io_rd_i && io_addr_i == `OAP_ARB_ADDR;
  endsequence
  sequence s_tx_load;
    !tbz[0] ##1 tbz[0];
  endsequence
  AST_ARB_PORT0: assert property (
    s_arb_rd ##0 (!iid_c[0][0] && !arb_pend_i) |=>
      io_rdata_en_o && io_rdata_o[6:4] == 3'h0)
    else $error("port 0 not reported first");
  AST_ARB_TYPE: assert property (
    s_arb_rd ##0 (pend_any && !arb_pend_i) |=>
      io_rdata_o[3:0] == $past(iid_c[port]) && io_rdata_o[3:0] != 4'h1)
    else $error("arbitration type wrong");
  AST_ARB_YIELD: assert property (
    s_arb_rd ##0 arb_pend_i |=> !io_rdata_en_o)
    else $error("answered while higher adapter pending");
  AST_IRQ_LOW: assert property (
    irq_req && slot[7] |=> irq_oe_n_o == ~(8'h01 << $past(slot[2:0])))
    else $error("request line not pulled low");
  AST_IRQ_FREE: assert property (
    !pend_any [*2] |=> irq_oe_n_o == 8'hFF)
    else $error("request line held without cause");
  AST_ONE_LINE: assert property ($onehot0(~irq_oe_n_o))
    else $error("more than one request line driven");
  AST_FIFO_CAP: assert property (
    5'(tw[0] - tr[0]) <= (fen[0] ? 5'h10 : 5'h01) &&
    5'(rw[0] - rr[0]) <= (fen[0] ? 5'h10 : 5'h01))
    else $error("fifo beyond its depth");
  AST_TX_START: assert property (
    s_tx_load ##0 (mcr[0][3] && !lcr[0][6]) |=> !txd_o[0])
    else $error("frame did not begin with a start bit");
  AST_IDLE_MARK: assert property (
    !tbz[0] && !lcr[0][6] && mcr[0][3] |=> txd_o[0])
    else $error("idle line not at mark");
  AST_INVERT: assert property (
    !tbz[0] && !lcr[0][6] && !mcr[0][3] |=> !txd_o[0])
    else $error("inverted idle line not low");
  AST_LS_FIRST: assert property (
    ier[0][2] && oe[0] |-> iid_c[0] == 4'h6)
    else $error("line status not highest");
endmodule : oap_adapter

// [test/oap_term.sv]
// Serial terminal model standing on the far side of the eight ports
module oap_term (
  // Lines from the adapter and polarity in force per port
  input wire logic [7:0] txd_i,
  input wire logic [7:0] inv_i,
  // Lines into the adapter
  output logic [7:0] rxd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // One bit at divisor 7 of the 768000 bit/s base rate
  parameter realtime BIT_NS = 9114.3;
  logic [7:0] space_q = 8'h00;

  // Mark is binary one; a port's inverted polarity flips the level
  assign rxd_o = ~space_q ^ inv_i;

  // Send one framed character, optionally with a wrong parity bit
  task automatic send(input int p, input logic [7:0] d, input int n,
      input logic pen, input logic even, input logic bad);
    logic par;
    par = ^(d & (8'hFF >> (8 - n))) ^ ~even ^ bad;
    space_q[p] = 1'b1;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      space_q[p] = ~d[i];
      #(BIT_NS);
    end
    if (pen) begin
      space_q[p] = ~par;
      #(BIT_NS);
    end
    space_q[p] = 1'b0;
    #(BIT_NS);
  endtask : send

  // Take one character at bit centres, ending in the stop bit
  task automatic recv(input int p, input int n, input logic pen,
      output logic [7:0] d, output logic par, output logic stp);
    d = 8'h00;
    par = 1'b0;
    wait ((txd_i[p] ^ inv_i[p]) == 1'b0);
    #(BIT_NS * 1.5);
    for (int i = 0; i < n; i++) begin
      d[i] = txd_i[p] ^ inv_i[p];
      #(BIT_NS);
    end
    if (pen) begin
      par = txd_i[p] ^ inv_i[p];
      #(BIT_NS);
    end
    stp = txd_i[p] ^ inv_i[p];
  endtask : recv
endmodule : oap_term

// [test/oap_adapter_tb.sv]
// Self-checking bench of the eight-port asynchronous adapter
module oap_adapter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus, observed outputs and bookkeeping
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_rd_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic arb_pend_i = 1'b0;
  logic [7:0] inv = 8'hFF;
  logic [7:0] cts = 8'h00;
  logic [7:0] rxd;
  logic [15:0] io_rdata_o;
  logic io_rdata_en_o;
  logic arb_pend_o;
  logic [7:0] irq_out_o, irq_oe_n_o, txd_o, rts_o, dtr_o;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [16:0] r;
  logic [7:0] d8, m;
  logic par, stp;

  // 100 MHz clock
  always #5 mclk_i = ~mclk_i;

  oap_adapter dut (.mclk_i(mclk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
    .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_rdata_en_o(io_rdata_en_o),
    .arb_pend_i(arb_pend_i), .arb_pend_o(arb_pend_o),
    .irq_out_o(irq_out_o), .irq_oe_n_o(irq_oe_n_o), .rxd_i(rxd),
    .cts_i(cts), .dsr_i(8'h00), .ri_i(8'h00), .dcd_i(8'h00),
    .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o));

  oap_term term (.txd_i(txd_o), .inv_i(inv), .rxd_o(rxd));

  // Verdict and end of run
  task end_of_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Compare a seen value against the expected one
  task chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Address of a channel register
  function automatic logic [15:0] ch(input int p, input logic [2:0] a);
    return 16'h0200 + 16'(p * 8) + {13'h0000, a};
  endfunction : ch

  // One-cycle write strobe
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge mclk_i);
    io_wr_i <= 1'b0;
  endtask : wr

  // One-cycle read strobe; answer is {valid, data} one cycle later
  task rd(input logic [15:0] a, output logic [16:0] q);
    @(posedge mclk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge mclk_i);
    io_rd_i <= 1'b0;
    #1;
    q = {io_rdata_en_o, io_rdata_o};
  endtask : rd

  // Normal polarity and modem outputs, then divisor 7 and the format
  task cfg(input int p, input logic [7:0] lcr);
    wr(ch(p, 3'h4), 8'h0B);
    inv[p] <= 1'b0;
    wr(ch(p, 3'h3), 8'h80);
    wr(ch(p, 3'h0), 8'h07);
    wr(ch(p, 3'h1), 8'h00);
    wr(ch(p, 3'h3), lcr);
  endtask : cfg

  // Hang guard
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(17'(irq_oe_n_o), 17'h000FF);
    chk(17'(txd_o), 17'h00000);
    chk(17'(arb_pend_o), 17'h00000);
    chk(17'(irq_out_o), 17'h00000);
    rd(16'h0300, r);
    chk(r, 17'h00000);
    cfg(0, 8'h03);
    repeat (2) @(posedge mclk_i);
    #1;
    chk(17'(txd_o[0]), 17'h00001);
    chk(17'({rts_o[0], dtr_o[0]}), 17'h00003);
    // Lengths five to eight with odd, even and no parity
    for (int i = 0; i < 4; i++) begin
      wr(ch(0, 3'h3), {3'h0, i[0], i < 3, 1'b0, i[1:0]});
      wr(ch(0, 3'h0), 8'hA5 ^ 8'(i));
      term.recv(0, 5 + i, i < 3, d8, par, stp);
      m = (8'hA5 ^ 8'(i)) & (8'hFF >> (3 - i));
      chk(17'(d8), 17'(m));
      chk(17'(par), 17'((i < 3) & (^m ^ ~i[0])));
      chk(17'(stp), 17'h00001);
      repeat (500) @(posedge mclk_i);
    end
    // Modem change on port 0: lowest source, cleared by reading its status
    wr(ch(0, 3'h1), 8'h08);
    cts[0] <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rd(ch(0, 3'h2), r);
    chk(r, 17'h10000);
    rd(ch(0, 3'h6), r);
    chk(r, 17'h10011);
    rd(ch(0, 3'h2), r);
    chk(r, 17'h10001);
    wr(ch(0, 3'h1), 8'h00);
    // Port 4 has no divisor, so its shifter keeps one byte; fill the FIFO
    wr(ch(4, 3'h2), 8'h01);
    for (int k = 0; k < 17; k++) wr(ch(4, 3'h0), 8'(k));
    rd(ch(4, 3'h5), r);
    chk(r, 17'h10000);
    rd(ch(4, 3'h2), r);
    chk(r, 17'h100C1);
    wr(ch(4, 3'h2), 8'h05);
    rd(ch(4, 3'h5), r);
    chk(r, 17'h10020);
    // Two ports receive at once; arbitration favours the lower port
    for (int p = 1; p < 4; p++) cfg(p, 8'h1B);
    wr(16'h0102, 8'hAA);
    wr(ch(1, 3'h1), 8'h01);
    wr(ch(3, 3'h1), 8'h01);
    fork
      term.send(1, 8'h3C, 8, 1'b1, 1'b1, 1'b0);
      term.send(3, 8'hC3, 8, 1'b1, 1'b1, 1'b0);
    join
    repeat (8) @(posedge mclk_i);
    #1;
    chk(17'(irq_oe_n_o), 17'h000FB);
    chk(17'(arb_pend_o), 17'h00001);
    rd(16'h0130, r);
    chk(r, 17'h10514);
    rd(ch(1, 3'h2), r);
    chk(r, 17'h10004);
    @(posedge mclk_i);
    arb_pend_i <= 1'b1;
    rd(16'h0130, r);
    chk(17'(r[16]), 17'h00000);
    @(posedge mclk_i);
    arb_pend_i <= 1'b0;
    rd(ch(1, 3'h0), r);
    chk(r, 17'h1003C);
    rd(16'h0130, r);
    chk(r, 17'h10534);
    rd(ch(3, 3'h0), r);
    chk(r, 17'h100C3);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(17'(irq_oe_n_o), 17'h000FF);
    rd(16'h0130, r);
    chk(17'(r[16]), 17'h00000);
    // Parity error on a port whose interrupts stay masked
    term.send(2, 8'h55, 8, 1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge mclk_i);
    #1;
    chk(17'(irq_oe_n_o), 17'h000FF);
    rd(ch(2, 3'h5), r);
    chk(r, 17'h10065);
    end_of_test();
  end
endmodule : oap_adapter_tb
